// ===== rtl/eep_host.sv
/*
 * Host controller for a parallel page-write EEPROM: issues the software
 * protection command sequences, loads 1 to 64 bytes into one page and then
 * polls the toggle status bit until the internal write is over.
 * Assumes the user side runs on the same clock and presents bytes with a
 * valid/ready handshake; the memory pins connect straight to the pin ports.
 */
`timescale 1ns/1ps
`default_nettype none
module eep_host #(
	// Poll time limit in cycles; default is the standard 10 ms write cycle.
	parameter int unsigned WC_LIMIT_CYC = eep_pkg::WC_STD_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire eep_pkg::eep_op_t op,
	input wire logic [6:0] page,
	input wire logic [6:0] count,
	input wire logic [7:0] byte_data,
	input wire logic byte_valid,
	output logic byte_ready,
	output logic busy,
	output logic done,
	output logic err_late,
	output logic err_timeout,
	output logic protect_on,
	output logic [12:0] ee_addr,
	output logic [7:0] ee_dout,
	output logic ee_dout_oe,
	input wire logic [7:0] ee_din,
	output logic ee_ce_n,
	output logic ee_oe_n,
	output logic ee_we_n
);

	// ************************************************************
	// State
	// ************************************************************
	eep_pkg::eep_state_t state_reg, state_next;   // Sequencer state.
	eep_pkg::eep_pins_t pins_reg, pins_next;      // Pin drive, straight to ports.
	eep_pkg::eep_op_t op_reg, op_next;            // Operation being run.
	logic [6:0] page_reg, page_next;              // Page select bits for the load.
	logic [6:0] count_reg, count_next;            // Bytes to load, 1 to 64.
	logic [6:0] idx_reg, idx_next;                // Command or byte index.
	logic cmd_reg, cmd_next;                      // Still sending the command.
	logic loaded_reg, loaded_next;                // At least one strobe sent.
	logic [11:0] timer_reg, timer_next;           // Phase timer.
	logic [31:0] poll_reg, poll_next;             // Cycles spent polling.
	logic last_reg, last_next;                    // Previous toggle bit read.
	logic have_reg, have_next;                    // A previous read exists.
	logic match_reg, match_next;                  // Two equal reads seen.
	logic ready_reg, ready_next;                  // Byte taken pulse.
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic late_reg, late_next;
	logic to_reg, to_next;
	logic prot_reg, prot_next;                    // Believed protection state.
	logic [7:0] din_sync;                         // Synchronised data lines.
	logic sample;                                 // Toggle bit of this read.

	// The data lines come from the memory, outside our timing.
	eep_sync3 #(.W(8)) u_sync (
		.clk(clk),
		.rst(rst),
		.din(ee_din),
		.q(din_sync)
	);

	assign sample = din_sync[eep_pkg::TOGGLE_BIT_POS];

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		pins_next = pins_reg;
		op_next = op_reg;
		page_next = page_reg;
		count_next = count_reg;
		idx_next = idx_reg;
		cmd_next = cmd_reg;
		loaded_next = loaded_reg;
		timer_next = timer_reg + 12'h001;
		poll_next = poll_reg;
		last_next = last_reg;
		have_next = have_reg;
		match_next = match_reg;
		ready_next = 1'b0;
		done_next = 1'b0;
		late_next = late_reg;
		to_next = to_reg;
		prot_next = prot_reg;
		if (state_reg == eep_pkg::EEP_POLL_LO || state_reg == eep_pkg::EEP_POLL_HI) begin
			poll_next = poll_reg + 32'h0000_0001;
		end
		case (state_reg)
			eep_pkg::EEP_IDLE: begin
				pins_next = eep_pkg::PINS_IDLE;
				pins_next.addr = pins_reg.addr;
				if (start) begin
					op_next = op;
					page_next = page;
					if (count == 7'h00) begin
						count_next = 7'h01;
					end else if (count > eep_pkg::PAGE_BYTES) begin
						count_next = eep_pkg::PAGE_BYTES;
					end else begin
						count_next = count;
					end
					cmd_next = (op != eep_pkg::EEP_OP_WRITE);
					idx_next = 7'h00;
					loaded_next = 1'b0;
					poll_next = 32'h0000_0000;
					have_next = 1'b0;
					match_next = 1'b0;
					late_next = 1'b0;
					to_next = 1'b0;
					timer_next = 12'h000;
					state_next = eep_pkg::EEP_LOAD;
				end
			end
			eep_pkg::EEP_LOAD: begin
				// output enable high
				// Output enable stays high for every write strobe.
				if (cmd_reg) begin
					pins_next.addr = eep_pkg::CMD_ADDR[idx_reg[1:0]];
					pins_next.dout = (op_reg == eep_pkg::EEP_OP_PROT_ON) ?
						eep_pkg::CMD_ON_DATA[idx_reg[1:0]] :
						eep_pkg::CMD_OFF_DATA[idx_reg[1:0]];
					pins_next.dout_oe = 1'b1;
					pins_next.ce_n = 1'b0;
					pins_next.we_n = 1'b0;
					timer_next = 12'h000;
					state_next = eep_pkg::EEP_STROBE_LO;
				end else if (byte_valid) begin
					pins_next.addr = {page_reg, idx_reg[5:0]};
					pins_next.dout = byte_data;
					pins_next.dout_oe = 1'b1;
					pins_next.ce_n = 1'b0;
					pins_next.we_n = 1'b0;
					ready_next = 1'b1;
					timer_next = 12'h000;
					state_next = eep_pkg::EEP_STROBE_LO;
				end else if (loaded_reg && timer_reg >= eep_pkg::BLC_CYC - 12'h001) begin
					// byte gap limit
					// The device has already closed the page; poll what it holds.
					late_next = 1'b1;
					pins_next.ce_n = 1'b0;
					pins_next.oe_n = 1'b0;
					timer_next = 12'h000;
					state_next = eep_pkg::EEP_POLL_LO;
				end else if (!loaded_reg) begin
					// Before the first strobe the user may take any time.
					timer_next = 12'h000;
				end
			end
			eep_pkg::EEP_STROBE_LO: begin
				// Rising write strobe latches address and data.
				if (timer_reg == eep_pkg::WP_CYC - 12'h001) begin
					pins_next.we_n = 1'b1;
					timer_next = 12'h000;
					state_next = eep_pkg::EEP_STROBE_HI;
				end
			end
			eep_pkg::EEP_STROBE_HI: begin
				if (timer_reg == eep_pkg::WPH_CYC - 12'h001) begin
					pins_next.ce_n = 1'b1;
					pins_next.dout_oe = 1'b0;
					loaded_next = 1'b1;
					timer_next = 12'h000;
					if (cmd_reg) begin
						if (idx_reg == 7'(eep_pkg::CMD_LEN - 1)) begin
							cmd_next = 1'b0;
							idx_next = 7'h00;
						end else begin
							idx_next = idx_reg + 7'h01;
						end
						state_next = eep_pkg::EEP_LOAD;
					end else if (idx_reg + 7'h01 == count_reg) begin
						// poll at last address
						// The address lines keep the last byte's address.
						pins_next.ce_n = 1'b0;
						pins_next.oe_n = 1'b0;
						state_next = eep_pkg::EEP_POLL_LO;
					end else begin
						idx_next = idx_reg + 7'h01;
						state_next = eep_pkg::EEP_LOAD;
					end
				end
			end
			eep_pkg::EEP_POLL_LO: begin
				if (timer_reg == eep_pkg::RD_CYC - 12'h001) begin
					match_next = have_reg && (sample == last_reg);
					last_next = sample;
					have_next = 1'b1;
					pins_next.ce_n = 1'b1;
					pins_next.oe_n = 1'b1;
					timer_next = 12'h000;
					state_next = eep_pkg::EEP_POLL_HI;
				end
			end
			eep_pkg::EEP_POLL_HI: begin
				if (timer_reg == eep_pkg::OEHP_CYC - 12'h001) begin
					timer_next = 12'h000;
					if (match_reg) begin
						state_next = eep_pkg::EEP_DONE;
					end else if (poll_reg >= WC_LIMIT_CYC) begin
						// Write never settled inside the longest write cycle.
						to_next = 1'b1;
						state_next = eep_pkg::EEP_DONE;
					end else begin
						pins_next.ce_n = 1'b0;
						pins_next.oe_n = 1'b0;
						state_next = eep_pkg::EEP_POLL_LO;
					end
				end
			end
			eep_pkg::EEP_DONE: begin
				done_next = 1'b1;
				// Only a settled protection write changes our belief.
				if (!to_reg && op_reg != eep_pkg::EEP_OP_WRITE) begin
					prot_next = (op_reg == eep_pkg::EEP_OP_PROT_ON);
				end
				state_next = eep_pkg::EEP_IDLE;
			end
			default: begin
				pins_next = eep_pkg::PINS_IDLE;
				state_next = eep_pkg::EEP_IDLE;
			end
		endcase
		busy_next = (state_next != eep_pkg::EEP_IDLE);
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= eep_pkg::EEP_IDLE;
			pins_reg <= eep_pkg::PINS_IDLE;
			op_reg <= eep_pkg::EEP_OP_WRITE;
			page_reg <= 7'h00;
			count_reg <= 7'h01;
			idx_reg <= 7'h00;
			cmd_reg <= 1'b0;
			loaded_reg <= 1'b0;
			timer_reg <= 12'h000;
			poll_reg <= 32'h0000_0000;
			last_reg <= 1'b0;
			have_reg <= 1'b0;
			match_reg <= 1'b0;
			ready_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			late_reg <= 1'b0;
			to_reg <= 1'b0;
			prot_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pins_reg <= pins_next;
			op_reg <= op_next;
			page_reg <= page_next;
			count_reg <= count_next;
			idx_reg <= idx_next;
			cmd_reg <= cmd_next;
			loaded_reg <= loaded_next;
			timer_reg <= timer_next;
			poll_reg <= poll_next;
			last_reg <= last_next;
			have_reg <= have_next;
			match_reg <= match_next;
			ready_reg <= ready_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			late_reg <= late_next;
			to_reg <= to_next;
			prot_reg <= prot_next;
		end
	end

	assign ee_addr = pins_reg.addr;
	assign ee_dout = pins_reg.dout;
	assign ee_dout_oe = pins_reg.dout_oe;
	assign ee_ce_n = pins_reg.ce_n;
	assign ee_oe_n = pins_reg.oe_n;
	assign ee_we_n = pins_reg.we_n;
	assign byte_ready = ready_reg;
	assign busy = busy_reg;
	assign done = done_reg;
	assign err_late = late_reg;
	assign err_timeout = to_reg;
	assign protect_on = prot_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_count_range;
		@(posedge clk) disable iff (rst)
		busy_reg |-> (count_reg >= 7'h01 && count_reg <= eep_pkg::PAGE_BYTES);
	endproperty
	a_count_range: assert property (p_count_range) else $error("page count out of range");

	property p_page_fixed;
		@(posedge clk) disable iff (rst)
		($fell(ee_we_n) && !cmd_reg) |-> (ee_addr[12:6] == page_reg);
	endproperty
	a_page_fixed: assert property (p_page_fixed) else $error("page bits moved");

	property p_oe_high;
		@(posedge clk) disable iff (rst)
		(!ee_we_n && !ee_ce_n) |-> ee_oe_n;
	endproperty
	a_oe_high: assert property (p_oe_high) else $error("output enable low in write");

	property p_poll_addr;
		@(posedge clk) disable iff (rst)
		(state_reg == eep_pkg::EEP_POLL_HI) ##1 (state_reg == eep_pkg::EEP_POLL_LO)
			|-> $stable(ee_addr);
	endproperty
	a_poll_addr: assert property (p_poll_addr) else $error("poll address changed");

	property p_cmd_addr;
		@(posedge clk) disable iff (rst)
		($fell(ee_we_n) && cmd_reg) |-> (ee_addr == eep_pkg::CMD_ADDR[idx_reg[1:0]]);
	endproperty
	a_cmd_addr: assert property (p_cmd_addr) else $error("wrong command address");

	property p_gap;
		@(posedge clk) disable iff (rst)
		(state_reg == eep_pkg::EEP_LOAD && loaded_reg) |-> (timer_reg < eep_pkg::BLC_CYC);
	endproperty
	a_gap: assert property (p_gap) else $error("byte gap too long");

	property p_first_read;
		@(posedge clk) disable iff (rst)
		$rose(match_reg) |-> $past(have_reg);
	endproperty
	a_first_read: assert property (p_first_read) else $error("match on first read");

	property p_done_match;
		@(posedge clk) disable iff (rst)
		$rose(done_reg) |-> (err_timeout || $past(match_reg, 2));
	endproperty
	a_done_match: assert property (p_done_match) else $error("done without equal reads");

	property p_wp_width;
		@(posedge clk) disable iff (rst)
		$fell(ee_we_n) |-> (!ee_we_n)[*3] ##1 ee_we_n;
	endproperty
	a_wp_width: assert property (p_wp_width) else $error("write pulse width wrong");

	c_prot_on: cover property (@(posedge clk) disable iff (rst)
		$rose(prot_reg));
	c_write: cover property (@(posedge clk) disable iff (rst)
		done_reg && op_reg == eep_pkg::EEP_OP_WRITE && !to_reg);
	c_timeout: cover property (@(posedge clk) disable iff (rst) $rose(to_reg));
	c_late: cover property (@(posedge clk) disable iff (rst) $rose(late_reg));

endmodule
`default_nettype wire

// ===== rtl/eep_pkg.sv
/*
 * Constants, types and timing figures for the host-side controller of a
 * byte-wide parallel EEPROM with a 64-byte page buffer, software write
 * protection and toggle-bit end-of-write detection.
 * Assumes a single 25 MHz clock and that the memory pins are wired directly
 * to the controller's pin ports.
 */
// How it works
// - Host loads one to sixty-four bytes.
// - Page bits constant on every data byte strobe fall.
// - Output enable high while writing.
// - Never assume toggle bit value; compare.
// - Poll reads keep one fixed address.
// - Commands: eight data, thirteen address lines.
// - Next byte within 150 us.
package eep_pkg;

	// ************************************************************
	// Clock and printed timing figures
	// ************************************************************
	localparam int unsigned CLK_NS = 40;        // Clock period in ns.
	localparam int unsigned T_WP_NS = 100;      // Least write pulse width.
	localparam int unsigned T_WPH_NS = 50;      // Least write pulse high time.
	localparam int unsigned T_ACC_NS = 150;     // Longest read access time.
	localparam int unsigned T_OEHP_NS = 150;    // Least output enable high pulse.
	localparam int unsigned T_BLC_US = 150;     // Longest byte load cycle.
	localparam int unsigned T_WC_STD_MS = 10;   // Longest write cycle, standard.
	localparam int unsigned T_WC_FAST_MS = 2;   // Longest write cycle, fast option.
	localparam int unsigned SYNC_CYC = 3;       // Stages in the pin synchroniser, one less than its latency.

	// ************************************************************
	// Derived cycle counts
	// ************************************************************
	localparam logic [11:0] WP_CYC = 12'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] WPH_CYC = 12'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] RD_CYC = 12'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
	localparam logic [11:0] OEHP_CYC = 12'((T_OEHP_NS + CLK_NS - 1) / CLK_NS);
	// A longest time rounds down, so the gap limit stays inside the window.
	localparam logic [11:0] BLC_CYC = 12'((T_BLC_US * 1000) / CLK_NS);
	localparam int unsigned WC_STD_CYC = (T_WC_STD_MS * 1000000) / CLK_NS;
	localparam int unsigned WC_FAST_CYC = (T_WC_FAST_MS * 1000000) / CLK_NS;

	// ************************************************************
	// Field positions and sizes
	// ************************************************************
	localparam int unsigned TOGGLE_BIT_POS = 6; // Toggle status bit on the data lines.
	localparam int unsigned PAGE_LSB = 6;       // Lowest page select bit.
	localparam logic [6:0] PAGE_BYTES = 7'h40;  // Bytes in one page.
	localparam int unsigned CMD_LEN = 3;        // Writes in a command sequence.

	// Command sequence addresses and bytes, earliest write at index 0 (listed last).
	localparam logic [2:0][12:0] CMD_ADDR = {13'h1555, 13'h0aaa, 13'h1555};
	localparam logic [2:0][7:0] CMD_ON_DATA = {8'ha0, 8'h55, 8'haa};
	localparam logic [2:0][7:0] CMD_OFF_DATA = {8'h80, 8'h55, 8'haa};

	// ************************************************************
	// Types
	// ************************************************************
	// Operation requested by the user side.
	typedef enum logic [1:0] {
		EEP_OP_WRITE = 2'h0,
		EEP_OP_PROT_ON = 2'h1,
		EEP_OP_PROT_OFF = 2'h2
	} eep_op_t;

	// Sequencer states, Gray coded along the path from EEP_IDLE to EEP_DONE.
	typedef enum logic [2:0] {
		EEP_IDLE = 3'h0,
		EEP_LOAD = 3'h1,
		EEP_STROBE_LO = 3'h3,
		EEP_STROBE_HI = 3'h2,
		EEP_POLL_LO = 3'h6,
		EEP_POLL_HI = 3'h7,
		EEP_DONE = 3'h5
	} eep_state_t;

	// Everything the controller drives onto the memory pins.
	typedef struct packed {
		logic [12:0] addr;
		logic [7:0] dout;
		logic dout_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} eep_pins_t;

	// Pins at rest: deselected, bus released.
	localparam eep_pins_t PINS_IDLE = '{addr: 13'h0000, dout: 8'h00, dout_oe: 1'b0,
		ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

endpackage

// ===== rtl/eep_sync3.sv
/*
 * Three-stage synchroniser for a bus of pin inputs.
 * Assumes the inputs come from outside the clock domain; a change is taken
 * only once the second and third stages agree.
 */
`timescale 1ns/1ps
`default_nettype none
module eep_sync3 #(
	parameter int unsigned W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] q
);

	// ************************************************************
	// Per-bit stages
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_reg;   // First stage, read only by the second.
			logic s2_reg;   // Second stage.
			logic s3_reg;   // Third stage.
			logic q_reg;    // Accepted level.
			logic q_next;   // Next accepted level.

			// Accept a new level only when stages two and three agree.
			always_comb begin
				q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
			end

			// Register the chain; reset puts constants only.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					q_reg <= 1'b0;
				end else begin
					s1_reg <= din[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					q_reg <= q_next;
				end
			end

			assign q[i] = q_reg;
		end
	endgenerate

endmodule
`default_nettype wire

// ===== verif/eep_dev_model.sv
/*
 * Pin-level behavioural model of the page-write EEPROM that the host drives.
 * Assumes registered host pins and no clock of its own; wr_ns sets how long
 * the internal write lasts, so the bench can make it prompt or slow.
 */
`timescale 1ns/1ps
`default_nettype none
module eep_dev_model (
	input wire logic [12:0] addr,
	input wire logic [7:0] dout,
	input wire logic dout_oe,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [31:0] wr_ns,
	output logic [7:0] din,
	output logic busy,
	output logic prot,
	output logic [7:0] viol
);
	// ************************************************************
	// Array, page latch and status
	// ************************************************************
	logic [7:0] mem [0:8191]; // Array contents, erased to all ones.
	logic [20:0] q [$]; // Latched {address, byte} of the current load.
	logic tog, on_ok, off_ok, have_pa, rd, wr_ok;
	logic [12:0] pa; // Address of the latest poll read.
	logic [7:0] cur, last;
	realtime t_end, t_we;
	int s, b;

	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		busy = 1'b0;
		prot = 1'b0;
		viol = 8'h00;
		tog = 1'b0;
		last = 8'h00;
		t_we = 0;
	end

	// A read needs both selects low and the strobe high.
	assign rd = !ce_n && !oe_n && we_n;
	assign cur = busy ? {mem[addr][7], tog, mem[addr][5:0]} : mem[addr];
	// Released lines show the inverse of the last value, so a stale read is caught.
	assign din = rd ? cur : ~last;
	always @(negedge rd) if (!$isunknown(cur)) last = cur;

	always @(posedge rd) begin
		if (busy) begin
			tog = ~tog;
			if (have_pa && addr !== pa) viol = viol + 8'h01;
			pa = addr;
			have_pa = 1'b1;
		end
	end

	always @(negedge we_n or negedge oe_n) begin
		#1;
		if (!we_n && !ce_n && !oe_n) viol = viol + 8'h01;
	end

	always @(posedge we_n) begin
		if (ce_n === 1'b0) begin
			if (!busy) begin
				q.delete();
				on_ok = 1'b1;
				off_ok = 1'b1;
				have_pa = 1'b0;
			end
			if (busy && $realtime - t_we > 150000) viol = viol + 8'h01;
			if (dout_oe !== 1'b1) viol = viol + 8'h01;
			s = q.size();
			if (s < 3) begin
				on_ok = on_ok && addr == eep_pkg::CMD_ADDR[s] && dout == eep_pkg::CMD_ON_DATA[s];
				off_ok = off_ok && addr == eep_pkg::CMD_ADDR[s] && dout == eep_pkg::CMD_OFF_DATA[s];
			end
			q.push_back({addr, dout});
			t_we = $realtime;
			t_end = t_we + wr_ns;
			busy = 1'b1;
		end
	end

	always @(posedge busy) begin
		while ($realtime < t_end) #10;
		b = (q.size() > 3 && (on_ok || off_ok)) ? 3 : 0;
		wr_ok = (b == 3) || !prot;
		if (b == 3) prot = on_ok;
		for (int i = b; i < q.size(); i++) begin
			if (q[i][20:14] !== q[b][20:14]) viol = viol + 8'h01;
			if (wr_ok) mem[q[i][20:8]] = q[i][7:0];
		end
		busy = 1'b0;
	end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
/*
 * Self-checking bench for the EEPROM host controller.
 * Assumes the device model sits on the memory pins and that the controller
 * is built with a short poll limit so the timeout case stays brief.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ************************************************************
	// Clock, stimulus and instances
	// ************************************************************
	localparam int unsigned LIMIT = 2000; // Short poll limit, 80 us.
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	eep_pkg::eep_op_t op = eep_pkg::EEP_OP_WRITE;
	logic [6:0] page = 7'h00;
	logic [6:0] count = 7'h01;
	logic [7:0] bidx = 8'h00; // Index of the byte on offer.
	logic bvalid = 1'b0;
	logic [31:0] wr_ns = 32'h0000_4e20; // Prompt internal write of 20 us.
	logic byte_ready, busy, done, err_late, err_timeout, protect_on;
	logic [12:0] ee_addr;
	logic [7:0] ee_dout, ee_din, viol;
	logic ee_dout_oe, ee_ce_n, ee_oe_n, ee_we_n, dev_busy, dev_prot;
	int num_errors = 0;
	int cmp_count = 0;

	// Byte pattern that varies the toggle bit value between bytes.
	function automatic logic [7:0] exp_byte(input logic [7:0] k);
		return 8'h1b + k * 8'h25;
	endfunction

	always #20 clk = ~clk;

	// Offsets restart with every request and advance on each accepted byte.
	always @(posedge clk) begin
		if (start) bidx <= 8'h00;
		else if (byte_ready) bidx <= bidx + 8'h01;
	end

	eep_host #(.WC_LIMIT_CYC(LIMIT)) eep_host_inst (.clk(clk), .rst(rst), .start(start),
		.op(op), .page(page), .count(count), .byte_data(exp_byte(bidx)), .byte_valid(bvalid),
		.byte_ready(byte_ready), .busy(busy), .done(done), .err_late(err_late),
		.err_timeout(err_timeout), .protect_on(protect_on), .ee_addr(ee_addr),
		.ee_dout(ee_dout), .ee_dout_oe(ee_dout_oe), .ee_din(ee_din), .ee_ce_n(ee_ce_n),
		.ee_oe_n(ee_oe_n), .ee_we_n(ee_we_n));

	eep_dev_model eep_dev_model_inst (.addr(ee_addr), .dout(ee_dout), .dout_oe(ee_dout_oe),
		.ce_n(ee_ce_n), .oe_n(ee_oe_n), .we_n(ee_we_n), .wr_ns(wr_ns), .din(ee_din),
		.busy(dev_busy), .prot(dev_prot), .viol(viol));

	// ************************************************************
	// Compare, request and closing tasks
	// ************************************************************
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// One request; a stall drops the byte offer after the first byte is taken.
	task automatic run_op(input eep_pkg::eep_op_t o, input logic [6:0] pg, input logic [6:0] n,
		input logic stall, input logic e_late, input logic e_to);
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		start <= 1'b1;
		op <= o;
		page <= pg;
		count <= n;
		bvalid <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (int i = 0; i < 20000 && done !== 1'b1; i++) begin
			@(posedge clk);
			if (stall && seen) bvalid <= 1'b0;
			#1;
			seen = seen || byte_ready === 1'b1;
		end
		chk_bit(done, 1'b1);
		chk_bit(busy, 1'b0);
		chk_bit(err_late, e_late);
		chk_bit(err_timeout, e_to);
		// A finished write must not be reported while the array is still busy.
		if (!e_to) chk_bit(dev_busy, 1'b0);
	endtask

	task automatic t_reset();
		chk_bit(ee_ce_n, 1'b1);
		chk_bit(ee_oe_n, 1'b1);
		chk_bit(ee_we_n, 1'b1);
		chk_bit(ee_dout_oe, 1'b0);
		chk_bit(protect_on, 1'b0);
	endtask

	task automatic t_write();
		run_op(eep_pkg::EEP_OP_WRITE, 7'h05, 7'h01, 1'b0, 1'b0, 1'b0);
		chk_byte(eep_dev_model_inst.mem[{7'h05, 6'h00}], exp_byte(8'h00));
		chk_bit(protect_on, 1'b0);
	endtask

	task automatic t_prot_on();
		run_op(eep_pkg::EEP_OP_PROT_ON, 7'h02, 7'h01, 1'b0, 1'b0, 1'b0);
		chk_bit(protect_on, 1'b1);
		chk_bit(dev_prot, 1'b1);
		chk_byte(eep_dev_model_inst.mem[{7'h02, 6'h00}], exp_byte(8'h00));
	endtask

	// A plain write while protected must leave the array untouched.
	task automatic t_blocked();
		run_op(eep_pkg::EEP_OP_WRITE, 7'h09, 7'h03, 1'b0, 1'b0, 1'b0);
		chk_byte(eep_dev_model_inst.mem[{7'h09, 6'h02}], 8'hff);
		chk_bit(protect_on, 1'b1);
	endtask

	// A slow array outlasts the poll limit; the belief must not change.
	task automatic t_timeout();
		@(posedge clk);
		wr_ns <= 32'h0003_0d40;
		run_op(eep_pkg::EEP_OP_PROT_OFF, 7'h0c, 7'h01, 1'b0, 1'b0, 1'b1);
		chk_bit(protect_on, 1'b1);
		for (int i = 0; i < 6000 && dev_busy !== 1'b0; i++) @(posedge clk);
		chk_bit(dev_busy, 1'b0);
		wr_ns <= 32'h0000_4e20;
	endtask

	// A count above a page is clamped to the full 64 bytes.
	task automatic t_prot_off();
		run_op(eep_pkg::EEP_OP_PROT_OFF, 7'h14, 7'h64, 1'b0, 1'b0, 1'b0);
		chk_bit(protect_on, 1'b0);
		chk_bit(dev_prot, 1'b0);
		chk_byte(eep_dev_model_inst.mem[{7'h14, 6'h3f}], exp_byte(8'h3f));
		chk_byte(eep_dev_model_inst.mem[{7'h15, 6'h00}], 8'hff);
	endtask

	task automatic t_late();
		run_op(eep_pkg::EEP_OP_WRITE, 7'h1e, 7'h04, 1'b1, 1'b1, 1'b0);
		chk_byte(eep_dev_model_inst.mem[{7'h1e, 6'h00}], exp_byte(8'h00));
		chk_byte(eep_dev_model_inst.mem[{7'h1e, 6'h01}], 8'hff);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_write();
		t_prot_on();
		t_blocked();
		t_timeout();
		t_prot_off();
		t_late();
		chk_byte(viol, 8'h00);
		summarize();
	end

	// The whole run needs about 11500 cycles; this cuts a hang short.
	initial begin
		#(40 * 60000);
		num_errors++;
		summarize();
	end
endmodule
`default_nettype wire
